// file: pkg/tph_pkg.sv
// package for the transmit packet handler configuration block
package tph_pkg;
  // register offsets
  localparam logic [5:0] ADDR_TX_FIFO_THRESHOLD = 6'h03;
  localparam logic [5:0] ADDR_SYNC_PATTERN_HIGH = 6'h04;
  localparam logic [5:0] ADDR_SYNC_PATTERN_LOW  = 6'h05;
  localparam logic [5:0] ADDR_FRAME_LENGTH      = 6'h06;
  localparam logic [5:0] ADDR_FRAME_CONTROL     = 6'h08;
  localparam logic [5:0] ADDR_NODE_ADDRESS      = 6'h09;
  localparam logic [5:0] ADDR_CHANNEL_INDEX     = 6'h0a;
  // reset values
  localparam logic [7:0] RST_TX_FIFO_THRESHOLD = 8'h07;
  localparam logic [7:0] RST_SYNC_PATTERN_HIGH = 8'hd3;
  localparam logic [7:0] RST_SYNC_PATTERN_LOW  = 8'h91;
  localparam logic [7:0] RST_FRAME_LENGTH      = 8'hff;
  localparam logic [7:0] RST_FRAME_CONTROL     = 8'h45;
  localparam logic [7:0] RST_NODE_ADDRESS      = 8'h00;
  localparam logic [7:0] RST_CHANNEL_INDEX     = 8'h00;
  // field positions in frame_control
  localparam int FC_WHITEN_BIT = 6;
  localparam int FC_FMT_HI     = 5;
  localparam int FC_FMT_LO     = 4;
  localparam int FC_LEGACY_BIT = 3;
  localparam int FC_CRC_BIT    = 2;
  localparam int FC_LEN_HI     = 1;
  localparam int FC_LEN_LO     = 0;
  // writable bits: bit 7 reads as zero
  localparam logic [7:0] FC_WRITE_MASK = 8'h7f;
  // threshold arithmetic
  localparam logic [6:0] THR_BASE_BYTES = 7'h3d;
  localparam int         THR_STEP_SHIFT = 2;
  // broadcast addresses
  localparam logic [7:0] BCAST_ADDR_LOW  = 8'h00;
  localparam logic [7:0] BCAST_ADDR_HIGH = 8'hff;

  typedef enum logic [1:0] {
    FMT_FIFO   = 2'h0,
    FMT_SERIAL = 2'h1,
    FMT_PN9    = 2'h2,
    FMT_ASYNC  = 2'h3
  } tph_format_type;

  typedef enum logic [1:0] {
    LEN_FIXED    = 2'h0,
    LEN_VARIABLE = 2'h1,
    LEN_INFINITE = 2'h2,
    LEN_RESERVED = 2'h3
  } tph_len_mode_type;

  // decoded configuration handed to the framer datapath
  typedef struct packed {
    logic [15:0]      sync_pattern;
    logic [7:0]       frame_length;
    tph_format_type   frame_format_select;
    tph_len_mode_type length_mode;
    logic             whitening_enable;
    logic             crc_enable;
    logic             legacy_crc_compat_enable;
    logic [7:0]       node_address;
    logic [7:0]       channel_index_value;
  } tph_cfg_type;

  // source and mode one-hot selects for the datapath
  typedef struct packed {
    logic use_tx_fifo;
    logic use_serial_sync;
    logic use_pn9;
    logic use_general_output_0;
    logic len_fixed;
    logic len_from_first_byte;
    logic len_unbounded;
  } tph_mode_type;
endpackage : tph_pkg

// file: verilog/tph_tx_packet_cfg.sv
// transmit packet handler configuration registers and decode
`timescale 1ns/100ps
// What this block does
// RULE_01: threshold exceeded when fifo count reaches it
// RULE_02: threshold bytes equal 61 minus four times setting
// RULE_03: host writes zero to reserved threshold bits
// RULE_04: sync pattern from high then low byte
// RULE_05: fixed frame length from length register
// RULE_06: format 0 takes payload from tx fifo
// RULE_07: format 1 selects serial synchronous mode
// RULE_08: format 2 sends pn9 test data
// RULE_09: format 3 takes data from general output 0
// RULE_10: legacy bit selects companion crc variant
// RULE_11: length mode 0 sends fixed length frames
// RULE_12: length mode 1 uses first byte length
// RULE_13: length mode 2 sends unbounded frames
// RULE_14: node address filter, broadcast 0 and 255
// RULE_15: channel index times spacing plus base
// RULE_16: bit 6 enables whitening, on after reset
// RULE_17: bit 2 enables crc, on after reset
// RULE_18: host never selects length mode 3
module tph_tx_packet_cfg
  import tph_pkg::*;
#(
  parameter int FIFO_CNT_W = 7,
  parameter int CHANNEL_INDEX_VALUE_SPACING_W = 16,
  parameter int FREQ_W = 24
) (
  // clock and reset
  input  wire logic                      sys_clk_in,
  input  wire logic                      srst_in,
  // register port, one access per cycle
  input  wire logic                      reg_wr_in,
  input  wire logic                      reg_rd_in,
  input  wire logic [5:0]                reg_addr_in,
  input  wire logic [7:0]                reg_wdata_in,
  output logic      [7:0]                reg_rdata_out,
  output logic                           reg_hit_out,
  // transmit fifo fill level and frequency inputs
  input  wire logic [FIFO_CNT_W-1:0]     tx_fifo_count_in,
  input  wire logic [CHANNEL_INDEX_VALUE_SPACING_W-1:0] channel_index_value_spacing_in,
  input  wire logic [FREQ_W-1:0]         base_freq_in,
  // decoded configuration
  output tph_cfg_type                    cfg_out,
  output tph_mode_type                   mode_out,
  output logic      [6:0]                tx_fill_threshold_out,
  output logic                           tx_threshold_exceeded_out,
  output logic      [FREQ_W-1:0]         oper_freq_out,
  output logic                           length_mode_reserved_out
);

  logic [7:0] tx_fifo_threshold_r, tx_fifo_threshold_nxt;
  logic [7:0] sync_pattern_high_r, sync_pattern_high_nxt;
  logic [7:0] sync_pattern_low_r,  sync_pattern_low_nxt;
  logic [7:0] frame_length_r,      frame_length_nxt;
  logic [7:0] frame_control_r,     frame_control_nxt;
  logic [7:0] node_address_r,      node_address_nxt;
  logic [7:0] channel_index_r,     channel_index_nxt;
  logic [7:0] rdata_r,             rdata_nxt;
  logic       hit_r,               hit_nxt;
  logic       thr_exc_r,           thr_exc_nxt;
  logic [6:0] thr_bytes_r,         thr_bytes_nxt;
  logic [FREQ_W-1:0] freq_r,       freq_nxt;

  function automatic logic [6:0] thr_bytes(input logic [3:0] setting);
    thr_bytes = THR_BASE_BYTES - {1'b0, setting, 2'b00}; // RULE_02
  endfunction

  function automatic logic is_broadcast(input logic [7:0] a);
    is_broadcast = (a == BCAST_ADDR_LOW) || (a == BCAST_ADDR_HIGH); // RULE_14
  endfunction

  // one map decode shared by the read hit flag and any later user
  function automatic logic is_mapped(input logic [5:0] a);
    unique case (a)
      ADDR_TX_FIFO_THRESHOLD, ADDR_SYNC_PATTERN_HIGH, ADDR_SYNC_PATTERN_LOW,
      ADDR_FRAME_LENGTH, ADDR_FRAME_CONTROL, ADDR_NODE_ADDRESS,
      ADDR_CHANNEL_INDEX: is_mapped = 1'b1;
      default:            is_mapped = 1'b0;
    endcase
  endfunction

  // write strobe for one register offset
  function automatic logic wr_sel(input logic       wr,
                                  input logic [5:0] a,
                                  input logic [5:0] target);
    wr_sel = wr && (a == target);
  endfunction

  // threshold register; reserved upper bits are stored as written,
  // the host keeps them zero
  always_comb begin
    tx_fifo_threshold_nxt = tx_fifo_threshold_r;
    if (wr_sel(reg_wr_in, reg_addr_in, ADDR_TX_FIFO_THRESHOLD)) begin
      tx_fifo_threshold_nxt = reg_wdata_in; // RULE_03
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      tx_fifo_threshold_r <= RST_TX_FIFO_THRESHOLD;
    end else begin
      tx_fifo_threshold_r <= tx_fifo_threshold_nxt;
    end
  end

  // sync pattern, high byte
  always_comb begin
    sync_pattern_high_nxt = sync_pattern_high_r;
    if (wr_sel(reg_wr_in, reg_addr_in, ADDR_SYNC_PATTERN_HIGH)) begin
      sync_pattern_high_nxt = reg_wdata_in; // RULE_04
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      sync_pattern_high_r <= RST_SYNC_PATTERN_HIGH;
    end else begin
      sync_pattern_high_r <= sync_pattern_high_nxt;
    end
  end

  // sync pattern, low byte
  always_comb begin
    sync_pattern_low_nxt = sync_pattern_low_r;
    if (wr_sel(reg_wr_in, reg_addr_in, ADDR_SYNC_PATTERN_LOW)) begin
      sync_pattern_low_nxt = reg_wdata_in; // RULE_04
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      sync_pattern_low_r <= RST_SYNC_PATTERN_LOW;
    end else begin
      sync_pattern_low_r <= sync_pattern_low_nxt;
    end
  end

  // fixed frame length
  always_comb begin
    frame_length_nxt = frame_length_r;
    if (wr_sel(reg_wr_in, reg_addr_in, ADDR_FRAME_LENGTH)) begin
      frame_length_nxt = reg_wdata_in; // RULE_05
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      frame_length_r <= RST_FRAME_LENGTH;
    end else begin
      frame_length_r <= frame_length_nxt;
    end
  end

  // frame control; the top bit is not stored so it always reads zero
  always_comb begin
    frame_control_nxt = frame_control_r;
    if (wr_sel(reg_wr_in, reg_addr_in, ADDR_FRAME_CONTROL)) begin
      frame_control_nxt = reg_wdata_in & FC_WRITE_MASK;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      frame_control_r <= RST_FRAME_CONTROL;
    end else begin
      frame_control_r <= frame_control_nxt;
    end
  end

  // node address for the downstream filter
  always_comb begin
    node_address_nxt = node_address_r;
    if (wr_sel(reg_wr_in, reg_addr_in, ADDR_NODE_ADDRESS)) begin
      node_address_nxt = reg_wdata_in; // RULE_14
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      node_address_r <= RST_NODE_ADDRESS;
    end else begin
      node_address_r <= node_address_nxt;
    end
  end

  // channel index
  always_comb begin
    channel_index_nxt = channel_index_r;
    if (wr_sel(reg_wr_in, reg_addr_in, ADDR_CHANNEL_INDEX)) begin
      channel_index_nxt = reg_wdata_in; // RULE_15
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      channel_index_r <= RST_CHANNEL_INDEX;
    end else begin
      channel_index_r <= channel_index_nxt;
    end
  end

  // read port: a read in the same cycle as a write returns the old value
  always_comb begin
    rdata_nxt = rdata_r;
    hit_nxt   = 1'b0;
    if (reg_rd_in) begin
      hit_nxt = is_mapped(reg_addr_in);
      unique case (reg_addr_in)
        ADDR_TX_FIFO_THRESHOLD: rdata_nxt = tx_fifo_threshold_r;
        ADDR_SYNC_PATTERN_HIGH: rdata_nxt = sync_pattern_high_r;
        ADDR_SYNC_PATTERN_LOW:  rdata_nxt = sync_pattern_low_r;
        ADDR_FRAME_LENGTH:      rdata_nxt = frame_length_r;
        ADDR_FRAME_CONTROL:     rdata_nxt = frame_control_r;
        ADDR_NODE_ADDRESS:      rdata_nxt = node_address_r;
        ADDR_CHANNEL_INDEX:     rdata_nxt = channel_index_r;
        default:                rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      rdata_r <= 8'h00;
      hit_r   <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      hit_r   <= hit_nxt;
    end
  end

  // status: registered so outputs come from flip-flops, one cycle behind count
  always_comb begin
    thr_bytes_nxt = thr_bytes(tx_fifo_threshold_r[3:0]); // RULE_02
    thr_exc_nxt   = ({1'b0, tx_fifo_count_in} >= {1'b0, thr_bytes_nxt}); // RULE_01
    // widen both factors first: a cast of the bare product would keep
    // only the spacing width and drop the upper product bits
    freq_nxt      = base_freq_in
                  + (FREQ_W'(channel_index_r) * FREQ_W'(channel_index_value_spacing_in)); // RULE_15
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      thr_exc_r   <= 1'b0;
      thr_bytes_r <= 7'h00;
      freq_r      <= '0;
    end else begin
      thr_exc_r   <= thr_exc_nxt;
      thr_bytes_r <= thr_bytes_nxt;
      freq_r      <= freq_nxt;
    end
  end

  // configuration decode; outputs are straight from register bits
  tph_format_type   fmt;
  tph_len_mode_type lmode;
  assign fmt   = tph_format_type'(frame_control_r[FC_FMT_HI:FC_FMT_LO]);
  assign lmode = tph_len_mode_type'(frame_control_r[FC_LEN_HI:FC_LEN_LO]);

  always_comb begin
    cfg_out.sync_pattern             = {sync_pattern_high_r, sync_pattern_low_r}; // RULE_04
    cfg_out.frame_length             = frame_length_r; // RULE_05
    cfg_out.frame_format_select      = fmt;
    cfg_out.length_mode              = lmode;
    cfg_out.whitening_enable         = frame_control_r[FC_WHITEN_BIT]; // RULE_16
    cfg_out.crc_enable               = frame_control_r[FC_CRC_BIT]; // RULE_17
    cfg_out.legacy_crc_compat_enable = frame_control_r[FC_LEGACY_BIT]; // RULE_10
    cfg_out.node_address             = node_address_r; // RULE_14
    cfg_out.channel_index_value      = channel_index_r;
  end

  always_comb begin
    mode_out.use_tx_fifo          = (fmt == FMT_FIFO); // RULE_06
    mode_out.use_serial_sync      = (fmt == FMT_SERIAL); // RULE_07
    mode_out.use_pn9              = (fmt == FMT_PN9); // RULE_08
    mode_out.use_general_output_0 = (fmt == FMT_ASYNC); // RULE_09
    mode_out.len_fixed            = (lmode == LEN_FIXED); // RULE_11
    mode_out.len_from_first_byte  = (lmode == LEN_VARIABLE); // RULE_12
    mode_out.len_unbounded        = (lmode == LEN_INFINITE); // RULE_13
  end

  // reserved length mode enables none of the length selects
  assign length_mode_reserved_out  = (lmode == LEN_RESERVED); // RULE_18
  assign tx_fill_threshold_out     = thr_bytes_r;
  assign tx_threshold_exceeded_out = thr_exc_r;
  assign oper_freq_out             = freq_r;
  assign reg_rdata_out             = rdata_r;
  assign reg_hit_out               = hit_r;

  logic unused_bcast;
  assign unused_bcast = is_broadcast(node_address_r);

endmodule // tph_tx_packet_cfg

// file: verif/tph_tx_packet_cfg_props.sv
// concurrent checks on the packet handler configuration ports
`timescale 1ns/100ps
module tph_tx_packet_cfg_props
  import tph_pkg::*;
#(
  parameter int FIFO_CNT_W     = 7,
  parameter int CHANNEL_INDEX_VALUE_SPACING_W = 16,
  parameter int FREQ_W         = 24
) (
  // clock, reset and writes
  input wire logic                  sys_clk_in,
  input wire logic                  srst_in,
  input wire logic                  reg_wr_in,
  input wire logic [5:0]            reg_addr_in,
  input wire logic [7:0]            reg_wdata_in,
  // fill level, frequency and decode
  input wire logic [FIFO_CNT_W-1:0] tx_fifo_count_in,
  input wire logic [CHANNEL_INDEX_VALUE_SPACING_W-1:0] channel_index_value_spacing_in,
  input wire logic [FREQ_W-1:0]     base_freq_in,
  input wire tph_cfg_type           cfg_out,
  input wire tph_mode_type          mode_out,
  input wire logic [6:0]            tx_fill_threshold_out,
  input wire logic                  tx_threshold_exceeded_out,
  input wire logic [FREQ_W-1:0]     oper_freq_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (srst_in);

  sequence s_wr(logic [5:0] a);
    reg_wr_in && reg_addr_in == a;
  endsequence
  // the threshold output is registered after the register, so it settles an edge later
  sequence s_thr_settled;
    s_wr(ADDR_TX_FIFO_THRESHOLD) ##1 1'b1;
  endsequence

  chk_fill_exceeded: assert property (
    !$past(srst_in) && $stable(tx_fill_threshold_out) |->
    tx_threshold_exceeded_out == ($past(tx_fifo_count_in) >= tx_fill_threshold_out))
    else $error("exceeded flag wrong");
  chk_thr_bytes: assert property (
    s_thr_settled |=> tx_fill_threshold_out == 7'(61 - 4 * $past(reg_wdata_in[3:0], 2)))
    else $error("threshold bytes wrong");
  chk_sync_high: assert property (
    s_wr(ADDR_SYNC_PATTERN_HIGH) |=> cfg_out.sync_pattern[15:8] == $past(reg_wdata_in))
    else $error("sync high byte wrong");
  chk_len_store: assert property (
    s_wr(ADDR_FRAME_LENGTH) |=> cfg_out.frame_length == $past(reg_wdata_in))
    else $error("frame length wrong");
  chk_ctrl_bits: assert property (
    s_wr(ADDR_FRAME_CONTROL) |=> {cfg_out.whitening_enable, cfg_out.legacy_crc_compat_enable,
    cfg_out.crc_enable} == {$past(reg_wdata_in[6]), $past(reg_wdata_in[3:2])})
    else $error("control bits wrong");
  chk_fmt_onehot: assert property (
    mode_out[6:3] == 4'h8 >> cfg_out.frame_format_select) else $error("format select wrong");
  chk_len_onehot: assert property (
    cfg_out.length_mode != LEN_RESERVED |-> mode_out[2:0] == 3'h4 >> cfg_out.length_mode)
    else $error("length select wrong");
  chk_freq_sum: assert property (
    !$past(srst_in) |-> oper_freq_out == $past(base_freq_in) +
    $past(cfg_out.channel_index_value) * $past(channel_index_value_spacing_in)) else $error("freq wrong");
endmodule // tph_tx_packet_cfg_props

bind tph_tx_packet_cfg tph_tx_packet_cfg_props #(.FIFO_CNT_W(FIFO_CNT_W),
  .CHANNEL_INDEX_VALUE_SPACING_W(CHANNEL_INDEX_VALUE_SPACING_W), .FREQ_W(FREQ_W)) u_props (.*);

// file: verif/tph_host_model.sv
// host model driving the register port one access at a time
`timescale 1ns/100ps
module tph_host_model (
  // clock
  input  wire logic       clk_in,
  // register port
  output logic            wr_out,
  output logic            rd_out,
  output logic [5:0]      addr_out,
  output logic [7:0]      wdata_out,
  input  wire logic [7:0] rdata_in
);
  initial {wr_out, rd_out, addr_out, wdata_out} = 16'h0000;
  // released lines flip so a stale value is never mistaken for a request
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_in);
    {wr_out, addr_out, wdata_out} <= {1'b1, a, d};
    @(posedge clk_in);
    {wr_out, addr_out, wdata_out} <= {1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_in);
    {rd_out, addr_out} <= {1'b1, a};
    @(posedge clk_in);
    {rd_out, addr_out} <= {1'b0, ~a};
    #1 d = rdata_in;
  endtask
endmodule // tph_host_model

// file: verif/testbench.sv
// self-checking bench for the packet handler configuration block
`timescale 1ns/100ps
module testbench;
  import tph_pkg::*;
  logic         sys_clk_in = 1'b0;
  logic         srst_in = 1'b1;
  logic         reg_wr_in, reg_rd_in, reg_hit_out;
  logic         tx_threshold_exceeded_out, length_mode_reserved_out;
  logic [5:0]   reg_addr_in;
  logic [7:0]   reg_wdata_in, reg_rdata_out, got, d;
  logic [6:0]   tx_fifo_count_in = 7'h00;
  logic [6:0]   tx_fill_threshold_out;
  logic [15:0]  channel_index_value_spacing_in = 16'h0000;
  logic [23:0]  base_freq_in = 24'h00_0000;
  logic [23:0]  oper_freq_out;
  tph_cfg_type  cfg_out;
  tph_mode_type mode_out;
  logic [7:0]   mdl [0:63] = '{3: 8'h07, 4: 8'hd3, 5: 8'h91, 6: 8'hff, 8: 8'h45, default: 8'h00};
  int           err_count = 0;
  int           checked = 0;
  int           cyc = 0;

  always #20 sys_clk_in = ~sys_clk_in;
  tph_tx_packet_cfg dut (.*);
  tph_host_model host (.clk_in(sys_clk_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in),
    .addr_out(reg_addr_in), .wdata_out(reg_wdata_in), .rdata_in(reg_rdata_out));

  task automatic check(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic rd_check(input logic [5:0] a);
    host.rd(a, got);
    check(got, mdl[a]);
    check(reg_hit_out, a inside {[6'h03:6'h06], [6'h08:6'h0a]});
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] v);
    host.wr(a, v);
    if (a inside {[6'h03:6'h06], [6'h09:6'h0a]}) mdl[a] = v;
    if (a == ADDR_FRAME_CONTROL) mdl[a] = v & FC_WRITE_MASK;
  endtask
  // status outputs are registered, so two edges pass before they are compared
  task automatic status(input logic [6:0] c);
    logic [6:0] t;
    logic [7:0] f;
    @(posedge sys_clk_in);
    tx_fifo_count_in <= c;
    channel_index_value_spacing_in <= 16'($urandom);
    base_freq_in <= 24'($urandom);
    repeat (2) @(posedge sys_clk_in);
    #1 t = 7'(61 - 4 * mdl[3][3:0]);
    f = mdl[8];
    check(tx_fill_threshold_out, t);
    check(tx_threshold_exceeded_out, c >= t);
    check(oper_freq_out, 24'(base_freq_in + mdl[10] * channel_index_value_spacing_in));
    check(cfg_out, {mdl[4], mdl[5], mdl[6], f[5:4], f[1:0], f[6], f[2], f[3], mdl[9], mdl[10]});
    check(mode_out, {4'h8 >> f[5:4], 3'h4 >> f[1:0]});
    check(length_mode_reserved_out, f[1:0] == 2'h3);
  endtask

  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      end_sim();
    end
  end

  initial begin
    logic [5:0] a;
    void'($urandom(75));
    repeat (20) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    for (int i = 0; i < 12; i++) rd_check(6'(i));
    status(7'h21);
    repeat (30) begin
      a = 6'($urandom_range(11));
      d = 8'($urandom);
      if (a == ADDR_TX_FIFO_THRESHOLD) d[7:4] = 4'h0;
      if (a == ADDR_FRAME_CONTROL && d[1:0] == 2'h3) d[1:0] = 2'h2;
      wr_reg(a, d);
      rd_check(a);
      status(7'($urandom_range(64)));
    end
    for (int m = 0; m < 16; m++) begin
      if (m % 4 == 3) continue;
      wr_reg(ADDR_FRAME_CONTROL, 8'(m / 4 * 16 + m % 4) | (8'($urandom) & 8'h4c));
      status(7'h00);
    end
    for (int s = 0; s < 16; s++) begin
      wr_reg(ADDR_TX_FIFO_THRESHOLD, 8'(s));
      status(7'(60 - 4 * s));
      status(7'(61 - 4 * s));
    end
    end_sim();
  end
endmodule // testbench
